// file: logic/ftf_pkg.sv
// constants for the flash timeout and fault flag register bank
package ftf_pkg;
    localparam logic [7:0] DUR_RESET = 8'h6f;
    localparam int TO_LSB = 0;
    localparam int TO_W = 5;
    localparam int CL_LSB = 5;
    localparam int CL_W = 2;
    localparam logic [4:0] TO_RESET = 5'h0f;
    localparam logic [1:0] CL_RESET = 2'h3;
    localparam int FLG_TIMEOUT = 0;
    localparam int FLG_THERMAL = 1;
    localparam int FLG_LED = 2;
    localparam int FLG_SYNC1 = 3;
    localparam int FLG_SYNC2 = 4;
    localparam int FLG_THERM = 5;
    localparam int FLG_FLASH_SUP = 6;
    localparam int FLG_SUP = 7;
    localparam logic [7:0] FLG_RESET = 8'h00;
    localparam int STEP_MS = 32;
    localparam int CLK_KHZ = 125000;
    localparam int STEP_CYCLES = STEP_MS * CLK_KHZ;
endpackage : ftf_pkg

// file: logic/ftf_regs.sv
// duration register, flash timer and clear-on-read fault flags
// Summary of operation
// - the timeout code gives a flash timeout of (code+1) steps of 32 ms.
// - reading the flags register clears every flag except one set in that same cycle, each flag holding until that read.
// - flag bits are timeout, thermal, led, sync1, sync2, thermistor, flash supply, supply; reset 0.
// - the led fault flag sets on an open or shorted led output.
// - each sync input flag sets on a change of that input while in sync-input mode.
// - the thermistor flag sets when sensing is enabled and the pin is below 1 V.
// - supply flags set when their monitor is enabled and the supply trips; the flash supply flag also needs the flash on.
`timescale 1ns/100ps
module ftf_regs #(
    parameter int STEP_CYCLES = ftf_pkg::STEP_CYCLES
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // register port from the serial bus engine
    input wire logic i_dur_wr,
    input wire logic [7:0] i_dur_wdata,
    input wire logic i_flags_rd,
    output logic [7:0] o_dur_rdata,
    output logic [7:0] o_flags_rdata,
    // flash control
    input wire logic i_flash_req,
    output logic o_flash_on,
    output logic [1:0] o_current_limit_sel,
    // raw conditions from pins and analog sensing
    input wire logic i_thermal_trip,
    input wire logic i_led_open_short,
    input wire logic i_pa_sync_in_first,
    input wire logic i_pa_sync_in_second,
    input wire logic i_sync1_mode,
    input wire logic i_sync2_mode,
    input wire logic i_thermistor_sense_en,
    input wire logic i_indicator_thermistor_pin_low,
    input wire logic i_sup_mon_en,
    input wire logic i_sup_below,
    input wire logic i_flash_sup_mon_en,
    input wire logic i_flash_sup_below
);
    localparam int NRAW = 8;
    // 0 thermal,1 led,2 sync1,3 sync2,4 therm pin,5 sup,6 flash sup,7 flash req
    logic [NRAW-1:0] raw_in;
    logic [NRAW-1:0] s1_reg;
    logic [NRAW-1:0] s2_reg;
    logic [NRAW-1:0] s3_reg;
    logic [2:0] prime_reg;
    logic [1:0] sync_chg;
    logic [4:0] to_reg;
    logic [4:0] to_next;
    logic [1:0] cl_reg;
    logic [1:0] cl_next;
    logic [7:0] flg_reg;
    logic [7:0] flg_next;
    logic [7:0] set_vec;
    logic [4:0] step_cnt_reg;
    logic [4:0] step_cnt_next;
    logic [31:0] cyc_reg;
    logic [31:0] cyc_next;
    logic on_reg;
    logic on_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic expire;

    assign raw_in = {i_flash_req, i_flash_sup_below, i_sup_below,
                     i_indicator_thermistor_pin_low, i_pa_sync_in_second,
                     i_pa_sync_in_first, i_led_open_short, i_thermal_trip};

    // two-stage synchroniser, third stage only for edge detection
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            prime_reg <= '0;
        end
        else
        begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            prime_reg <= {prime_reg[1:0], 1'b1};
        end
    end

    // edge detectors stay blind until the third stage holds pin data, so a pin
    // that is already high at reset release is not taken as a change
    assign sync_chg = {2{prime_reg[2]}} & (s2_reg[3:2] ^ s3_reg[3:2]);

    always_comb
    begin
        to_next = to_reg;
        cl_next = cl_reg;
        if (i_dur_wr)
        begin
            to_next = i_dur_wdata[ftf_pkg::TO_LSB +: ftf_pkg::TO_W];
            cl_next = i_dur_wdata[ftf_pkg::CL_LSB +: ftf_pkg::CL_W];
        end
    end

    // end of one step of the flash timer
    function automatic logic at_step_end(input logic [31:0] cyc);
        return cyc == 32'(STEP_CYCLES - 1);
    endfunction : at_step_end

    // flash timer: steps of 32 ms, expiry after code+1 steps; >= so a shorter code
    // written during a flash ends it at the current step instead of wrapping round
    assign expire = on_reg && at_step_end(cyc_reg) && (step_cnt_reg >= to_reg);

    always_comb
    begin
        on_next = on_reg;
        cyc_next = cyc_reg;
        step_cnt_next = step_cnt_reg;
        if (!on_reg)
        begin
            cyc_next = '0;
            step_cnt_next = '0;
            // a new flash needs a fresh request edge
            on_next = prime_reg[2] && s2_reg[7] && !s3_reg[7];
        end
        else if (!s2_reg[7])
        begin
            on_next = 1'b0;
        end
        else if (expire)
        begin
            on_next = 1'b0;
        end
        else if (at_step_end(cyc_reg))
        begin
            cyc_next = '0;
            step_cnt_next = step_cnt_reg + 5'h01;
        end
        else
        begin
            cyc_next = cyc_reg + 32'h1;
        end
    end

    always_comb
    begin
        set_vec = '0;
        set_vec[ftf_pkg::FLG_TIMEOUT] = expire;
        set_vec[ftf_pkg::FLG_THERMAL] = s2_reg[0];
        set_vec[ftf_pkg::FLG_LED] = s2_reg[1];
        set_vec[ftf_pkg::FLG_SYNC1] = i_sync1_mode && sync_chg[0];
        set_vec[ftf_pkg::FLG_SYNC2] = i_sync2_mode && sync_chg[1];
        set_vec[ftf_pkg::FLG_THERM] = i_thermistor_sense_en && s2_reg[4];
        set_vec[ftf_pkg::FLG_SUP] = i_sup_mon_en && s2_reg[5];
        set_vec[ftf_pkg::FLG_FLASH_SUP] = i_flash_sup_mon_en && on_reg && s2_reg[6];
        // read snapshot is taken before the clear; a same-cycle set survives
        rdata_next = rdata_reg;
        if (i_flags_rd)
        begin
            rdata_next = flg_reg;
        end
        flg_next = (i_flags_rd ? 8'h00 : flg_reg) | set_vec;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            to_reg <= ftf_pkg::TO_RESET;
            cl_reg <= ftf_pkg::CL_RESET;
            flg_reg <= ftf_pkg::FLG_RESET;
            on_reg <= 1'b0;
            cyc_reg <= '0;
            step_cnt_reg <= '0;
            rdata_reg <= '0;
        end
        else
        begin
            to_reg <= to_next;
            cl_reg <= cl_next;
            flg_reg <= flg_next;
            on_reg <= on_next;
            cyc_reg <= cyc_next;
            step_cnt_reg <= step_cnt_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_dur_rdata = {1'b0, cl_reg, to_reg};
    assign o_flags_rdata = rdata_reg;
    assign o_flash_on = on_reg;
    assign o_current_limit_sel = cl_reg;

    clear_on_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_flags_rd && !(|set_vec) |=> flg_reg == 8'h00) else $error("flags not cleared");
    read_snapshot_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_flags_rd |=> o_flags_rdata == $past(flg_reg)) else $error("bad flag readback");
    read_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !i_flags_rd |=> $stable(o_flags_rdata)) else $error("flag readback changed");
    sticky_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !i_flags_rd |=> (flg_reg & $past(flg_reg)) == $past(flg_reg)) else $error("flag lost");
    timeout_end_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        expire |=> !o_flash_on && flg_reg[0]) else $error("timeout did not end flash");
    thermal_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        s2_reg[0] |=> flg_reg[1]) else $error("thermal flag");
    sync_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !i_sync1_mode && !i_flags_rd && !flg_reg[3] |=> !flg_reg[3]) else $error("sync1 flag");
    sync2_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !i_sync2_mode && !i_flags_rd && !flg_reg[4] |=> !flg_reg[4]) else $error("sync2 flag");
    sync_edge_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_sync1_mode && sync_chg[0] |=> flg_reg[3]) else $error("sync1 change missed");
    therm_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_thermistor_sense_en && s2_reg[4] |=> flg_reg[5]) else $error("thermistor flag");
    led_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        s2_reg[1] |=> flg_reg[2]) else $error("led flag");
    sup_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_sup_mon_en && s2_reg[5] |=> flg_reg[7]) else $error("supply flag");
    flash_sup_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_flash_sup_mon_en && o_flash_on && s2_reg[6] |=> flg_reg[6])
        else $error("flash supply flag");
    flash_sup_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !(i_flash_sup_mon_en && o_flash_on) && !i_flags_rd && !flg_reg[6] |=> !flg_reg[6])
        else $error("flash supply gate");
    dur_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_dur_wr |=> o_dur_rdata[6:0] == $past(i_dur_wdata[6:0])) else $error("dur write");
    cl_out_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !i_dur_wr |=> $stable(o_current_limit_sel)) else $error("limit sel");
endmodule : ftf_regs

// file: tb/ftf_host.sv
// host model issuing register write and read pulses
`timescale 1ns/100ps
module ftf_host (
    // clock
    input wire logic i_core_clk,
    // register port
    output logic o_dur_wr,
    output logic [7:0] o_dur_wdata,
    output logic o_flags_rd
);
    initial
    begin
        o_dur_wr = 1'b0;
        o_dur_wdata = 8'h00;
        o_flags_rd = 1'b0;
    end
    // data is inverted once released so a stale bus cannot look valid
    task automatic wr(input logic [7:0] d);
        @(negedge i_core_clk);
        o_dur_wr = 1'b1;
        o_dur_wdata = d;
        @(negedge i_core_clk);
        o_dur_wr = 1'b0;
        o_dur_wdata = ~d;
    endtask : wr
    task automatic rd;
        @(negedge i_core_clk);
        o_flags_rd = 1'b1;
        @(negedge i_core_clk);
        o_flags_rd = 1'b0;
    endtask : rd
endmodule : ftf_host

// file: tb/flash_timeout_and_fault_flags_tb.sv
// self-checking bench for the flash timeout and fault flag bank
`timescale 1ns/100ps
module flash_timeout_and_fault_flags_tb;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_flash_req = 1'b0;
    logic [6:0] ev = 7'h00;
    logic [4:0] en = 5'h1f;
    logic wr, rd, on;
    logic [7:0] wd, dur, flg;
    logic [1:0] cl;
    int mismatches = 0;
    int checks = 0;
    initial
    begin
        forever #4 i_core_clk = ~i_core_clk;
    end
    ftf_host u_ftf_host (.i_core_clk(i_core_clk), .o_dur_wr(wr), .o_dur_wdata(wd),
        .o_flags_rd(rd));
    // short step keeps a flash to a few cycles
    ftf_regs #(.STEP_CYCLES(4)) u_ftf_regs (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_dur_wr(wr), .i_dur_wdata(wd), .i_flags_rd(rd), .o_dur_rdata(dur),
        .o_flags_rdata(flg), .i_flash_req(i_flash_req), .o_flash_on(on),
        .o_current_limit_sel(cl), .i_thermal_trip(ev[0]), .i_led_open_short(ev[1]),
        .i_pa_sync_in_first(ev[2]), .i_pa_sync_in_second(ev[3]), .i_sync1_mode(en[0]),
        .i_sync2_mode(en[1]), .i_thermistor_sense_en(en[2]),
        .i_indicator_thermistor_pin_low(ev[4]), .i_sup_mon_en(en[3]), .i_sup_below(ev[5]),
        .i_flash_sup_mon_en(en[4]), .i_flash_sup_below(ev[6]));
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic complete_run;
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic reset_values;
        chk("dur", 8'h6f, dur);
        chk("limit", 8'h03, {6'h00, cl});
        u_ftf_host.rd();
        chk("flags", 8'h00, flg);
    endtask : reset_values
    task automatic write_fields;
        for (int c = 0; c < 4; c++)
        begin
            u_ftf_host.wr({1'b1, c[1:0], 5'h1f});
            chk("dur", {1'b0, c[1:0], 5'h1f}, dur);
            chk("limit", {6'h00, c[1:0]}, {6'h00, cl});
        end
    endtask : write_fields
    task automatic wait_on;
        int w;
        w = 0;
        while (on !== 1'b1 && w < 10)
        begin
            @(negedge i_core_clk);
            w++;
        end
        if (on !== 1'b1)
        begin
            chk("flash start", 8'h01, {7'h00, on});
            complete_run();
        end
    endtask : wait_on
    // counts the cycles the flash stands after a fresh request edge
    task automatic flash_len(input logic [7:0] e);
        int c;
        c = 0;
        i_flash_req = 1'b1;
        wait_on();
        while (on === 1'b1 && c < 300)
        begin
            @(negedge i_core_clk);
            c++;
        end
        chk("flash cycles", e, (c >= 300) ? 8'hff : c[7:0]);
        if (c >= 300)
            complete_run();
    endtask : flash_len
    task automatic flash_timeout;
        u_ftf_host.wr(8'h01);
        flash_len(8'h08);
        i_flash_req = 1'b0;
        u_ftf_host.rd();
        chk("flags", 8'h01, flg);
        u_ftf_host.rd();
        chk("flags", 8'h00, flg);
        u_ftf_host.wr(8'h00);
        flash_len(8'h04);
        i_flash_req = 1'b0;
        u_ftf_host.rd();
        chk("flags", 8'h01, flg);
    endtask : flash_timeout
    task automatic flash_supply;
        en = 5'h1f;
        u_ftf_host.wr(8'h1f);
        i_flash_req = 1'b1;
        wait_on();
        ev[6] = 1'b1;
        repeat (5) @(negedge i_core_clk);
        ev[6] = 1'b0;
        i_flash_req = 1'b0;
        repeat (5) @(negedge i_core_clk);
        chk("flash on", 8'h00, {7'h00, on});
        u_ftf_host.rd();
        chk("flags", 8'h40, flg);
        // with the flash off the flash-time supply trip is ignored
        ev[6] = 1'b1;
        repeat (5) @(negedge i_core_clk);
        ev[6] = 1'b0;
        repeat (5) @(negedge i_core_clk);
        u_ftf_host.rd();
        chk("flags", 8'h00, flg);
    endtask : flash_supply
    // pins held high across a reset must not look like a change or a request
    task automatic midrun_reset;
        u_ftf_host.wr(8'h00);
        ev[2] = 1'b1;
        i_flash_req = 1'b1;
        i_rst_b = 1'b0;
        repeat (5) @(negedge i_core_clk);
        chk("dur", 8'h6f, dur);
        i_rst_b = 1'b1;
        repeat (5) @(negedge i_core_clk);
        chk("flash on", 8'h00, {7'h00, on});
        u_ftf_host.rd();
        chk("flags", 8'h00, flg);
        ev[2] = 1'b0;
        i_flash_req = 1'b0;
        repeat (5) @(negedge i_core_clk);
        u_ftf_host.rd();
        chk("flags", 8'h08, flg);
        flash_len(8'h40);
        i_flash_req = 1'b0;
        u_ftf_host.rd();
        chk("flags", 8'h01, flg);
    endtask : midrun_reset
    task automatic events;
        int pos [6] = '{1, 2, 3, 4, 5, 7};
        for (int k = 0; k < 6; k++)
        begin
            ev[k] = 1'b1;
            repeat (5) @(negedge i_core_clk);
            ev[k] = 1'b0;
            repeat (5) @(negedge i_core_clk);
            u_ftf_host.rd();
            chk("flags", 8'h01 << pos[k], flg);
        end
        // every enable off: none of the gated sources may flag
        en = 5'h00;
        ev = 7'h7c;
        repeat (5) @(negedge i_core_clk);
        ev = 7'h00;
        repeat (5) @(negedge i_core_clk);
        u_ftf_host.rd();
        chk("masked", 8'h00, flg);
    endtask : events
    initial
    begin
        repeat (5) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        reset_values();
        write_fields();
        flash_timeout();
        events();
        flash_supply();
        midrun_reset();
        complete_run();
    end
endmodule : flash_timeout_and_fault_flags_tb
